//--- core/bmx_mux_ctrl.sv
// How it works
// - Calibration bit ties cal pins to nodes
// - Two-bit field picks skin load resistor
// - Skin load bit closes drive-input loads
// - Guard bit drives 2A/3A with inputs
// - Compensation bit enables input cap compensation
// - Positive input goes to 1, 2A, 2B
// - Negative input goes to 4, 3A, 3B
// - Calibration bit disconnects all electrode pins
// - Positive drive select; modes 1,2 force 1
// - Negative drive select; modes 1,2 force 4
// - Read-only signed factory resistor error value
// - Lead-on only with both channels off
// - Lead-off needs a channel; four flags
// - External bit moves lead-off to 2B/3B
// - Drive monitor flags out-of-range event
// - Polarity bit swaps source and sink
// - Mux disabled opens every pin
// - Drive mode 3 means no stimulus
// - Current magnitude code 0 disables sources
`timescale 1ns/1ps
`default_nettype none
`include "bmx_defines.svh"

module bmx_mux_ctrl #(
    parameter logic [7:0] SELFTEST_ERR = `BMX_RST_ERR  // Factory trim, arbitrary default
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // Avalon-MM slave
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [1:0]  AVS_RESPONSE,
    // Analog comparator events
    input  wire logic [3:0]  LOFF_CMP,
    input  wire logic        DRIVE_OUT_OF_RANGE_CMP,
    // Electrode switches: bit0 electrode 1, bit1 electrode 2a, bit2 electrode 2b
    output logic      [2:0]  RX_POS_SW,
    output logic      [2:0]  DRIVE_POS_SW,
    // Electrode switches: bit0 electrode 4, bit1 electrode 3a, bit2 electrode 3b
    output logic      [2:0]  RX_NEG_SW,
    output logic      [2:0]  DRIVE_NEG_SW,
    // Calibration pins 1..4
    output logic      [3:0]  CAL_SW,
    // Internal loads
    output logic      [3:0]  SKIN_LOAD_SW,
    output logic      [3:0]  SELFTEST_LOAD_SW,
    output logic             GUARD_DRIVE_ON,
    output logic             INPUT_COMP_ON,
    // Lead detection controls
    output logic             LEAD_ON_ACTIVE,
    output logic             LEAD_OFF_ACTIVE,
    output logic             LEAD_OFF_EXTERNAL,
    output logic             LEAD_OFF_POS_SOURCE,
    output logic      [2:0]  LEAD_OFF_MAG,
    output logic             DRV_MONITOR_ON,
    output logic             STIMULUS_ON
);

    // Configuration registers
    logic [7:0] mux1_reg;
    logic [7:0] mux2_reg;
    logic [7:0] mux3_reg;
    logic [7:0] dclead_reg;
    logic [7:0] chan_reg;
    logic [4:0] status_reg;
    bmx_pkg::bmx_bus_state_t bus_reg;

    // Bus decode
    logic       req;
    logic [7:0] idx;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wdat;
    logic       hit;
    assign req   = AVS_READ | AVS_WRITE;
    assign idx   = AVS_ADDRESS[9:2];
    assign wdat  = AVS_WRITEDATA[7:0];
    assign wr_go = AVS_WRITE & (bus_reg == bmx_pkg::BMX_BUS_IDLE) & AVS_BYTEENABLE[0];
    assign rd_go = AVS_READ & (bus_reg == bmx_pkg::BMX_BUS_IDLE);

    // Three-way electrode decode, shared by inputs and drives
    function automatic logic [2:0] pin_decode(input logic [1:0] code);
        logic [2:0] v;
        v = 3'h0;
        unique case (code)
            2'h0: v = 3'h1;
            2'h1: v = 3'h2;
            2'h2: v = 3'h4;
            default: v = 3'h0;  // Forbidden code leaves pin open
        endcase
        return v;
    endfunction

    // Address hit check
    always_comb begin
        unique case (idx)
            `BMX_IDX_MUX1, `BMX_IDX_MUX2, `BMX_IDX_MUX3, `BMX_IDX_MUX4,
            `BMX_IDX_DCLEAD, `BMX_IDX_CHAN, `BMX_IDX_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // One wait cycle then done; done returns to idle without waiting to see the release
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bus_reg <= bmx_pkg::BMX_BUS_IDLE;
        end else if (bus_reg == bmx_pkg::BMX_BUS_IDLE && req) begin
            bus_reg <= bmx_pkg::BMX_BUS_DONE;
        end else begin
            bus_reg <= bmx_pkg::BMX_BUS_IDLE;
        end
    end

    // Waitrequest high while idle, so every request waits exactly one cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !(bus_reg == bmx_pkg::BMX_BUS_IDLE && req);
        end
    end

    // Register writes, reserved bits masked off
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mux1_reg   <= `BMX_RST_CFG;
            mux2_reg   <= `BMX_RST_CFG;
            mux3_reg   <= `BMX_RST_CFG;
            dclead_reg <= `BMX_RST_CFG;
            chan_reg   <= `BMX_RST_CFG;
        end else if (wr_go) begin
            unique case (idx)
                `BMX_IDX_MUX1:   mux1_reg   <= wdat & `BMX_M1_MASK;
                `BMX_IDX_MUX2:   mux2_reg   <= wdat & `BMX_M2_MASK;
                `BMX_IDX_MUX3:   mux3_reg   <= wdat;
                `BMX_IDX_DCLEAD: dclead_reg <= wdat;
                `BMX_IDX_CHAN:   chan_reg   <= wdat & `BMX_CH_MASK;
                default: ;  // Error register is read-only
            endcase
        end
    end

    // Read data and response; unmapped gives slave error and zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_READDATA <= 32'h0;
            AVS_RESPONSE <= 2'h0;
        end else if (rd_go || (AVS_WRITE && bus_reg == bmx_pkg::BMX_BUS_IDLE)) begin
            AVS_RESPONSE <= hit ? 2'h0 : 2'h2;
            AVS_READDATA <= 32'h0;
            if (rd_go) begin
                unique case (idx)
                    `BMX_IDX_MUX1:   AVS_READDATA <= {24'h0, mux1_reg};
                    `BMX_IDX_MUX2:   AVS_READDATA <= {24'h0, mux2_reg};
                    `BMX_IDX_MUX3:   AVS_READDATA <= {24'h0, mux3_reg};
                    `BMX_IDX_MUX4:   AVS_READDATA <= {24'h0, SELFTEST_ERR};
                    `BMX_IDX_DCLEAD: AVS_READDATA <= {24'h0, dclead_reg};
                    `BMX_IDX_CHAN:   AVS_READDATA <= {24'h0, chan_reg};
                    `BMX_IDX_STATUS: AVS_READDATA <= {27'h0, status_reg};
                    default:         AVS_READDATA <= 32'h0;
                endcase
            end
        end
    end

    // Field extraction
    logic       mux_en;
    logic       cal_en;
    logic       cal_only;
    logic       chan_on;
    logic [1:0] mode;
    logic       forced;
    assign mux_en   = mux1_reg[`BMX_M1_MUX_EN];
    assign cal_en   = mux1_reg[`BMX_M1_CAL_EN];
    assign cal_only = mux1_reg[`BMX_M1_CAL_ONLY];
    assign chan_on  = chan_reg[`BMX_CH_I_EN] | chan_reg[`BMX_CH_Q_EN];
    assign mode     = chan_reg[`BMX_CH_MODE_LO +: 2];
    assign forced   = (mode == bmx_pkg::BMX_DRV_VOLTAGE) || (mode == bmx_pkg::BMX_DRV_HBRIDGE);

    // Electrodes connect only with mux on and calibration off
    logic el_on;
    assign el_on = mux_en & ~cal_en;

    // Electrode switch enables, registered so writes never glitch pins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RX_POS_SW    <= 3'h0;
            RX_NEG_SW    <= 3'h0;
            DRIVE_POS_SW <= 3'h0;
            DRIVE_NEG_SW <= 3'h0;
        end else begin
            RX_POS_SW <= el_on ? pin_decode(mux3_reg[`BMX_M3_RX_POS_LO +: 2]) : 3'h0;
            RX_NEG_SW <= el_on ? pin_decode(mux3_reg[`BMX_M3_RX_NEG_LO +: 2]) : 3'h0;
            if (!el_on) begin
                DRIVE_POS_SW <= 3'h0;
                DRIVE_NEG_SW <= 3'h0;
            end else if (forced) begin
                DRIVE_POS_SW <= 3'h1;
                DRIVE_NEG_SW <= 3'h1;
            end else begin
                DRIVE_POS_SW <= pin_decode(mux3_reg[`BMX_M3_DRV_POS_LO +: 2]);
                DRIVE_NEG_SW <= pin_decode(mux3_reg[`BMX_M3_DRV_NEG_LO +: 2]);
            end
        end
    end

    // Calibration pins: drive pos, rx pos, rx neg, drive neg; cal-only is moot since cal opens electrodes
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CAL_SW <= 4'h0;
        end else begin
            CAL_SW <= (mux_en & cal_en) ? 4'hf : 4'h0;
        end
    end

    // Internal loads: one-hot resistor choice while connect bit set
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SKIN_LOAD_SW     <= 4'h0;
            SELFTEST_LOAD_SW <= 4'h0;
            GUARD_DRIVE_ON   <= 1'b0;
            INPUT_COMP_ON    <= 1'b0;
        end else begin
            SKIN_LOAD_SW <= mux2_reg[`BMX_M2_LOAD_EN]
                ? 4'(4'h1 << mux2_reg[`BMX_M2_RSEL_LO +: 2]) : 4'h0;
            SELFTEST_LOAD_SW <= mux1_reg[`BMX_M1_BIST_EN]
                ? 4'(4'h1 << mux1_reg[`BMX_M1_RSEL_LO +: 2]) : 4'h0;
            GUARD_DRIVE_ON <= mux2_reg[`BMX_M2_GUARD_EN];
            INPUT_COMP_ON  <= mux2_reg[`BMX_M2_COMP_EN];
        end
    end

    // Lead detection controls; host may leave mux on under load, nothing blocks it
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            LEAD_ON_ACTIVE      <= 1'b0;
            LEAD_OFF_ACTIVE     <= 1'b0;
            LEAD_OFF_EXTERNAL   <= 1'b0;
            LEAD_OFF_POS_SOURCE <= 1'b0;
            LEAD_OFF_MAG        <= 3'h0;
            DRV_MONITOR_ON      <= 1'b0;
            STIMULUS_ON         <= 1'b0;
        end else begin
            LEAD_ON_ACTIVE      <= dclead_reg[`BMX_DC_LON_EN] & ~chan_on;
            LEAD_OFF_ACTIVE     <= dclead_reg[`BMX_DC_LOFF_EN] & chan_on;
            LEAD_OFF_EXTERNAL   <= dclead_reg[`BMX_DC_EXT_EN];
            LEAD_OFF_POS_SOURCE <= ~dclead_reg[`BMX_DC_IPOL];
            LEAD_OFF_MAG        <= dclead_reg[`BMX_DC_IMAG_LO +: 3];
            DRV_MONITOR_ON      <= dclead_reg[`BMX_DC_OOR_EN];
            STIMULUS_ON         <= (mode != bmx_pkg::BMX_DRV_STANDBY);
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    logic [4:0] st_set;
    logic [4:0] st_clr;
    assign st_set = {DRIVE_OUT_OF_RANGE_CMP & DRV_MONITOR_ON, LOFF_CMP & {4{LEAD_OFF_ACTIVE}}};
    assign st_clr = (wr_go && idx == `BMX_IDX_STATUS) ? wdat[4:0] : 5'h0;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_reg <= 5'h0;
        end else begin
            status_reg <= (status_reg & ~st_clr) | st_set;
        end
    end

endmodule
`default_nettype wire

//--- core/bmx_defines.svh
`ifndef BMX_DEFINES_SVH
`define BMX_DEFINES_SVH

// Register word offsets (index); byte address is four times the index
`define BMX_IDX_MUX1        8'h41
`define BMX_IDX_MUX2        8'h42
`define BMX_IDX_MUX3        8'h43
`define BMX_IDX_MUX4        8'h44
`define BMX_IDX_DCLEAD      8'h50
`define BMX_IDX_CHAN        8'h60
`define BMX_IDX_STATUS      8'h61

// Mux configuration 1 fields
`define BMX_M1_CAL_EN       0
`define BMX_M1_MUX_EN       1
`define BMX_M1_CAL_ONLY     2
`define BMX_M1_BIST_EN      5
`define BMX_M1_RSEL_LO      6
`define BMX_M1_MASK         8'he7

// Mux configuration 2 fields
`define BMX_M2_COMP_EN      0
`define BMX_M2_GUARD_EN     1
`define BMX_M2_LOAD_EN      5
`define BMX_M2_RSEL_LO      6
`define BMX_M2_MASK         8'he3

// Mux configuration 3 fields
`define BMX_M3_DRV_NEG_LO   0
`define BMX_M3_DRV_POS_LO   2
`define BMX_M3_RX_NEG_LO    4
`define BMX_M3_RX_POS_LO    6

// DC lead configuration fields
`define BMX_DC_IMAG_LO      0
`define BMX_DC_IPOL         3
`define BMX_DC_OOR_EN       4
`define BMX_DC_EXT_EN       5
`define BMX_DC_LOFF_EN      6
`define BMX_DC_LON_EN       7

// Channel control register fields
`define BMX_CH_I_EN         0
`define BMX_CH_Q_EN         1
`define BMX_CH_MODE_LO      2
`define BMX_CH_MASK         8'h0f

// Status register fields
`define BMX_ST_NL           0
`define BMX_ST_NH           1
`define BMX_ST_PL           2
`define BMX_ST_PH           3
`define BMX_ST_OOR          4

// Reset values
`define BMX_RST_CFG         8'h00
`define BMX_RST_ERR         8'h00

`endif

//--- core/bmx_pkg.sv
`default_nettype none
package bmx_pkg;

    // Stimulus drive modes
    typedef enum logic [1:0] {
        BMX_DRV_CURRENT = 2'h0,
        BMX_DRV_VOLTAGE = 2'h1,
        BMX_DRV_HBRIDGE = 2'h2,
        BMX_DRV_STANDBY = 2'h3
    } bmx_drv_mode_t;

    // Bus slave answer sequencing
    typedef enum logic [1:0] {
        BMX_BUS_IDLE = 2'b01,
        BMX_BUS_DONE = 2'b10
    } bmx_bus_state_t;

endpackage
`default_nettype wire

//--- testbench/bmx_mux_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bmx_mux_ctrl_chk (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_B,
    // Bus handshake
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [31:0] AVS_READDATA,
    input wire logic [1:0]  AVS_RESPONSE,
    // Switch controls
    input wire logic [2:0]  RX_POS_SW,
    input wire logic [2:0]  RX_NEG_SW,
    input wire logic [2:0]  DRIVE_POS_SW,
    input wire logic [2:0]  DRIVE_NEG_SW,
    input wire logic [3:0]  CAL_SW,
    input wire logic [3:0]  SKIN_LOAD_SW,
    input wire logic        LEAD_ON_ACTIVE,
    input wire logic        LEAD_OFF_ACTIVE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    // Calibration and electrode paths never share the nodes
    a_cal_opens_el: assert property (|CAL_SW |-> {RX_POS_SW, RX_NEG_SW, DRIVE_POS_SW, DRIVE_NEG_SW} == 12'h000)
        else $error("electrode closed while calibration pins connected");
    a_cal_all_four: assert property (CAL_SW == 4'h0 || CAL_SW == 4'hf)
        else $error("calibration pins switched partially");
    a_rx_single: assert property ($onehot0(RX_POS_SW) && $onehot0(RX_NEG_SW))
        else $error("receive node on two electrodes");
    a_drive_single: assert property ($onehot0(DRIVE_POS_SW) && $onehot0(DRIVE_NEG_SW))
        else $error("drive node on two electrodes");
    a_skin_single: assert property ($onehot0(SKIN_LOAD_SW))
        else $error("two skin loads closed");
    a_lead_excl: assert property (!(LEAD_ON_ACTIVE && LEAD_OFF_ACTIVE))
        else $error("lead-on and lead-off detectors both active");
    // Switches move only after a completed write, so no glitch between settings
    a_hold_cfg: assert property (!$past(AVS_WRITE && !AVS_WAITREQUEST) |->
        $stable({RX_POS_SW, RX_NEG_SW, DRIVE_POS_SW, DRIVE_NEG_SW, CAL_SW, SKIN_LOAD_SW}))
        else $error("switch changed without a write");
    a_rd_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_ack_pulse: assert property ($fell(AVS_WAITREQUEST) |=> $rose(AVS_WAITREQUEST))
        else $error("waitrequest low longer than one cycle");
    a_ack_bound: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered next cycle");
    c_cal: cover property (CAL_SW == 4'hf);
    c_loff: cover property (LEAD_OFF_ACTIVE);
    c_unmapped: cover property (!AVS_WAITREQUEST && AVS_RESPONSE == 2'b10);
endmodule
bind bmx_mux_ctrl bmx_mux_ctrl_chk u_chk (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA), .AVS_RESPONSE(AVS_RESPONSE),
    .RX_POS_SW(RX_POS_SW), .RX_NEG_SW(RX_NEG_SW), .DRIVE_POS_SW(DRIVE_POS_SW), .DRIVE_NEG_SW(DRIVE_NEG_SW),
    .CAL_SW(CAL_SW), .SKIN_LOAD_SW(SKIN_LOAD_SW), .LEAD_ON_ACTIVE(LEAD_ON_ACTIVE),
    .LEAD_OFF_ACTIVE(LEAD_OFF_ACTIVE)
);
`default_nettype wire

//--- testbench/bmx_host.sv
`timescale 1ns/1ps
`default_nettype none
module bmx_host (
    // Clock
    input  wire logic        clk,
    // Avalon-MM master side
    output logic      [9:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    input  wire logic [1:0]  response
);
    initial begin
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
    end
    // One access; the idle gap lets a clock edge pass before the next raise
    task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d, input int gap,
                       output logic [31:0] rd, output logic [1:0] rsp, output logic ok);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge clk);
        address <= {idx, 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        ok = (waitrequest === 1'b0);
        rd = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~writedata; // Released data shows no stale value
    endtask
endmodule
`default_nettype wire

//--- testbench/bmx_mux_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmx_defines.svh"
module bmx_mux_ctrl_test;
    localparam logic [7:0] TRIM = 8'hc0; // Arbitrary negative trim
    localparam logic [7:0] IDX [5] = '{`BMX_IDX_MUX1, `BMX_IDX_MUX2, `BMX_IDX_MUX3, `BMX_IDX_DCLEAD, `BMX_IDX_CHAN};
    localparam logic [7:0] MSK [5] = '{`BMX_M1_MASK, `BMX_M2_MASK, 8'hff, 8'hff, `BMX_CH_MASK};
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  loff_cmp = 4'h0;
    logic        oor_cmp = 1'b0;
    logic [31:0] rdv;
    logic [1:0]  rsv;
    logic [7:0]  cfg [5] = '{default: 8'h00};
    int          errors = 0;
    int          checks_done = 0;
    wire logic [9:0]  adr;
    wire logic        rd_s, wr_s, wreq;
    wire logic [31:0] wd, rdata;
    wire logic [3:0]  be;
    wire logic [1:0]  resp;
    wire logic [34:0] outs;
    always #25 core_clk = ~core_clk;
    bmx_host host (.clk(core_clk), .address(adr), .read(rd_s), .write(wr_s), .writedata(wd), .byteenable(be),
        .waitrequest(wreq), .readdata(rdata), .response(resp));
    bmx_mux_ctrl #(.SELFTEST_ERR(TRIM)) uut (.CORE_CLK(core_clk), .RST_B(rst_b), .AVS_ADDRESS(adr),
        .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .LOFF_CMP(loff_cmp), .DRIVE_OUT_OF_RANGE_CMP(oor_cmp),
        .RX_POS_SW(outs[34:32]), .DRIVE_POS_SW(outs[31:29]), .RX_NEG_SW(outs[28:26]), .DRIVE_NEG_SW(outs[25:23]),
        .CAL_SW(outs[22:19]), .SKIN_LOAD_SW(outs[18:15]), .SELFTEST_LOAD_SW(outs[14:11]),
        .GUARD_DRIVE_ON(outs[10]), .INPUT_COMP_ON(outs[9]), .LEAD_ON_ACTIVE(outs[8]), .LEAD_OFF_ACTIVE(outs[7]),
        .LEAD_OFF_EXTERNAL(outs[6]), .LEAD_OFF_POS_SOURCE(outs[5]), .LEAD_OFF_MAG(outs[4:2]),
        .DRV_MONITOR_ON(outs[1]), .STIMULUS_ON(outs[0]));
    // Code 3 leaves the node open
    function automatic logic [2:0] sel(input logic e, input logic [1:0] c);
        return (e && c != 2'h3) ? 3'h1 << c : 3'h0;
    endfunction
    // Expected switch word from the shadow configuration
    function automatic logic [34:0] exp_sw(input logic [7:0] m1, m2, m3, dc, ch);
        logic el;
        logic fix;
        el = m1[1] & !m1[0];
        fix = ch[3:2] == 2'h1 || ch[3:2] == 2'h2;
        return {sel(el, m3[7:6]), sel(el, fix ? 2'h0 : m3[3:2]), sel(el, m3[5:4]), sel(el, fix ? 2'h0 : m3[1:0]),
            {4{m1[1] & m1[0]}}, m2[5] ? 4'h1 << m2[7:6] : 4'h0, m1[5] ? 4'h1 << m1[7:6] : 4'h0, m2[1], m2[0],
            dc[7] & !(|ch[1:0]), dc[6] & |ch[1:0], dc[5], !dc[3], dc[2:0], dc[4], ch[3:2] != 2'h3};
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_out(input string nm, input logic [34:0] e, input logic [34:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // A hung slave ends the run through the closing report
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        logic ok;
        host.acc(w, idx, d, $urandom_range(2), rdv, rsv, ok);
        if (!ok) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic cfg_set(input int k, input logic [7:0] d);
        cfg[k] = d & MSK[k];
        bus(1'b1, IDX[k], d);
    endtask
    task automatic rd_chk(input int k);
        bus(1'b0, IDX[k], 8'h00);
        chk_bus("config readback", {24'h0, cfg[k]}, rdv);
        chk_bus("config response", 32'h0, {30'h0, rsv});
    endtask
    task automatic check_sw;
        @(posedge core_clk);
        #1;
        chk_out("switch outputs", exp_sw(cfg[0], cfg[1], cfg[2], cfg[3], cfg[4]), outs);
    endtask
    initial begin
        void'($urandom(83212));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 5; k++) rd_chk(k);
        check_sw;
        bus(1'b1, `BMX_IDX_MUX4, 8'hff);
        bus(1'b0, `BMX_IDX_MUX4, 8'h00);
        chk_bus("resistor error", {24'h0, TRIM}, rdv);
        bus(1'b0, 8'h45, 8'h00);
        chk_bus("unmapped response", {30'h0, 2'b10}, {30'h0, rsv});
        chk_bus("unmapped data", 32'h0, rdv);
        $display("test registers done");
        cfg_set(0, 8'h02);
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 4; c++) begin
                cfg_set(4, {4'h0, m[1:0], 2'h1});
                cfg_set(2, {4{c[1:0]}}); // Code 0 keeps drives on electrodes 1 and 4
                check_sw;
            end
        end
        for (int i = 0; i < 4; i++) begin
            cfg_set(0, {5'h0, i[1:0], 1'b1});
            check_sw;
        end
        $display("test routing done");
        cfg_set(0, 8'h00); // Matrix and calibration off while the skin load is used
        for (int g = 0; g < 4; g++) begin
            cfg_set(1, {g[1:0], 1'b1, 3'h0, g[1:0]});
            check_sw;
        end
        cfg_set(1, 8'hc0);
        check_sw;
        for (int i = 0; i < 8; i++) begin
            cfg_set(4, {4'h0, i[2:1], i[1:0]});
            cfg_set(3, {2'h3, 6'($urandom)});
            check_sw;
        end
        cfg_set(4, 8'h01);
        cfg_set(3, 8'h50);
        loff_cmp <= 4'ha;
        oor_cmp <= 1'b1;
        bus(1'b0, `BMX_IDX_STATUS, 8'h00);
        chk_bus("status flags", 32'h1a, rdv);
        loff_cmp <= 4'h0;
        oor_cmp <= 1'b0;
        bus(1'b1, `BMX_IDX_STATUS, 8'h1f);
        cfg_set(3, 8'h00);
        loff_cmp <= 4'hf;
        oor_cmp <= 1'b1;
        bus(1'b0, `BMX_IDX_STATUS, 8'h00);
        chk_bus("status gated", 32'h0, rdv);
        $display("test detection done");
        for (int i = 0; i < 80; i++) begin
            int k;
            k = $urandom_range(4);
            loff_cmp <= 4'($urandom);
            cfg_set(k, 8'($urandom));
            check_sw;
            rd_chk(k);
        end
        $display("test random done");
        end_sim();
    end
endmodule
`default_nettype wire
